// ==== design/async_rx_pkg.sv ====
// Constants, register map and types for the asynchronous serial receiver.
package async_rx_pkg;

  // ==========================================================================
  // Bus and register map
  localparam int          ADDR_W     = 5;
  localparam int          DATA_W     = 32;
  localparam int          REG_W      = 8;
  localparam logic [4:0]  OFS_TXCTL  = 5'h00;
  localparam logic [4:0]  OFS_RXCTL  = 5'h04;
  localparam logic [4:0]  OFS_RXDATA = 5'h08;
  localparam logic [4:0]  OFS_BAUD   = 5'h0C;
  localparam logic [4:0]  OFS_IRQCTL = 5'h10;
  localparam logic [4:0]  OFS_IRQFLG = 5'h14;

  // ==========================================================================
  // Reset values
  localparam logic [7:0]  TXCTL_RST  = 8'h02;
  localparam logic [7:0]  RXCTL_RST  = 8'h00;
  localparam logic [7:0]  BAUD_RST   = 8'h00;

  // ==========================================================================
  // Transmit control/status bit positions
  localparam int TX_CLKSRC  = 7;
  localparam int TX_NINE    = 6;
  localparam int TX_ENABLE  = 5;
  localparam int TX_SYNC    = 4;
  localparam int TX_HISPEED = 2;
  localparam int TX_SHEMPTY = 1;
  localparam int TX_NINTHD  = 0;

  // ==========================================================================
  // Receive control/status bit positions
  localparam int RX_PORTEN  = 7;
  localparam int RX_NINE    = 6;
  localparam int RX_SINGLE  = 5;
  localparam int RX_CONT    = 4;
  localparam int RX_ADDRDET = 3;
  localparam int RX_FRAMING_ERROR    = 2;
  localparam int RX_OVERRUN_ERROR    = 1;
  localparam int RX_NINTHD  = 0;

  // ==========================================================================
  // Interrupt control bits and flag bit
  localparam int IRQ_RXEN   = 0;
  localparam int IRQ_PERIEN = 1;
  localparam int IRQ_GLOBEN = 2;
  localparam int FLG_RXRDY  = 0;

  // ==========================================================================
  // Timing: oversampling, low-speed prescale of the baud timer and sample points; FIFO depth
  localparam int         OVERSAMPLE   = 16;
  localparam int         LOW_PRESCALE = 4;
  localparam logic [3:0] SAMPLE_A     = 4'h7;
  localparam logic [3:0] SAMPLE_B     = 4'h8;
  localparam logic [3:0] SAMPLE_VOTE  = 4'h9;
  localparam int         FIFO_DEPTH   = 2;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } rxState_t;

endpackage

// ==== design/async_serial_receiver_ctl.sv ====
// Asynchronous serial receiver with two-entry FIFO and Avalon-MM registers.
`timescale 1ns/100ps
module async_serial_receiver_ctl (
  input  wire logic                            core_clk,
  input  wire logic                            rst_n,
  input  wire logic [async_rx_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                            avs_read,
  input  wire logic                            avs_write,
  input  wire logic [async_rx_pkg::DATA_W-1:0] avs_writedata,
  input  wire logic [3:0]                      avs_byteenable,
  output logic      [async_rx_pkg::DATA_W-1:0] avs_readdata,
  output logic                                 avs_waitrequest,
  input  wire logic                            rxPinIn,
  output logic                                 rxPinOut,
  output logic                                 rxPinOe,
  output logic                                 txPinOut,
  output logic                                 txPinOe,
  output logic                                 rxReadyFlag,
  output logic                                 rxIrq,
  output logic                                 txPathEnable,
  output logic                                 syncClockMaster
);
  import async_rx_pkg::*;

  // ==========================================================================
  // Declarations
  logic [7:0]      txCtl_q;
  logic [7:0]      rxCtl_q;
  logic [7:0]      baud_q;
  logic [2:0]      irqCtl_q;
  logic [7:0]      lastData_q;
  logic [9:0]      fifoMem_q [FIFO_DEPTH];
  logic            wrPtr_q;
  logic            rdPtr_q;
  logic [1:0]      count_q;
  logic            overrun_q;
  rxState_t        state_q;
  logic [3:0]      tickCnt_q;
  logic [3:0]      bitIdx_q;
  logic [8:0]      shift_q;
  logic            sampA_q;
  logic            sampB_q;
  logic            rxPrev_q;
  logic [7:0]      rdMux;
  logic            accept;
  logic            wrEvt;
  logic            popEvt;
  logic            portEn;
  logic            syncMode;
  logic            nineBit;
  logic            addrFilter;
  logic            rxRun;
  logic            tick;
  logic            vote;
  logic            evalTick;
  logic            deliverEvt;
  logic            keepChar;
  logic            pushEvt;
  logic            overrunSet;
  logic            stopLow;
  logic [9:0]      newEntry;
  logic [9:0]      headEntry;
  logic [3:0]      lastIdx;

  // ==========================================================================
  // Bus handshake: one wait cycle, then the access completes
  assign accept = (avs_read || avs_write) && !avs_waitrequest;
  assign wrEvt  = accept && avs_write && avs_byteenable[0];
  assign popEvt = accept && avs_read && (avs_address == OFS_RXDATA) && (count_q != 2'd0);

  // Waitrequest drops for exactly one cycle per request
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      avs_waitrequest <= 1'b1;
    else if ((avs_read || avs_write) && avs_waitrequest)
      avs_waitrequest <= 1'b0;
    else
      avs_waitrequest <= 1'b1;
  end

  // Read mux; framing error and ninth bit reflect the oldest unread character
  always_comb
  begin
    rdMux = 8'h00;
    case (avs_address)
      OFS_TXCTL:  rdMux = {txCtl_q[7:4], 1'b0, txCtl_q[2], 1'b1, txCtl_q[0]};
      OFS_RXCTL:  rdMux = {rxCtl_q[7:3], headEntry[9], overrun_q, headEntry[8]};
      OFS_RXDATA: rdMux = (count_q != 2'd0) ? headEntry[7:0] : lastData_q;
      OFS_BAUD:   rdMux = baud_q;
      OFS_IRQCTL: rdMux = {5'h00, irqCtl_q};
      OFS_IRQFLG: rdMux = {7'h00, rxReadyFlag};
      default:    rdMux = 8'h00;
    endcase
  end

  // Read data is loaded in the cycle waitrequest goes low
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      avs_readdata <= '0;
    else if (avs_read && avs_waitrequest)
      avs_readdata <= {24'h000000, rdMux};
  end

  // ==========================================================================
  // Software control registers
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      txCtl_q <= TXCTL_RST;
    else if (wrEvt && avs_address == OFS_TXCTL)
      txCtl_q <= {avs_writedata[7:4], 1'b0, avs_writedata[2], 1'b1, avs_writedata[0]};
  end

  // Single receive clears itself after a synchronous-master character unless continuous receive is also set
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      rxCtl_q <= RXCTL_RST;
    else
    begin
      if (wrEvt && avs_address == OFS_RXCTL)
        rxCtl_q <= {avs_writedata[7:3], 3'b000};
      if (deliverEvt && syncMode && txCtl_q[TX_CLKSRC] && !rxCtl_q[RX_CONT])
        rxCtl_q[RX_SINGLE] <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      baud_q <= BAUD_RST;
    else if (wrEvt && avs_address == OFS_BAUD)
      baud_q <= avs_writedata[7:0];
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      irqCtl_q <= 3'b000;
    else if (wrEvt && avs_address == OFS_IRQCTL)
      irqCtl_q <= avs_writedata[2:0];
  end

  // ==========================================================================
  // Mode decode
  assign portEn     = rxCtl_q[RX_PORTEN];
  assign syncMode   = txCtl_q[TX_SYNC];
  assign nineBit    = rxCtl_q[RX_NINE];
  // Filter only in nine-bit asynchronous operation; eight-bit ignores it
  assign addrFilter = rxCtl_q[RX_ADDRDET] && nineBit && !syncMode;
  // Continuous receive always counts; single only for synchronous master
  assign rxRun      = portEn && !overrun_q &&
                      (rxCtl_q[RX_CONT] || (syncMode && txCtl_q[TX_CLKSRC] &&
                       rxCtl_q[RX_SINGLE]));
  assign lastIdx    = nineBit ? 4'd8 : 4'd7;

  // Baud tick: speed select matters only asynchronously
  baud_tick #(
    .DIV_W (8),
    .PRE_W (2)
  ) u_baud (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clear    (!portEn || (wrEvt && avs_address == OFS_BAUD)),
    .lowSpeed (!syncMode && !txCtl_q[TX_HISPEED]),
    .divisor  (baud_q),
    .tick     (tick)
  );

  // ==========================================================================
  // Data recovery: majority of three samples around mid-bit
  assign vote     = (sampA_q && sampB_q) || (sampA_q && rxPinIn) || (sampB_q && rxPinIn);
  assign evalTick = tick && (tickCnt_q == SAMPLE_VOTE);

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      rxPrev_q <= 1'b1;
    else
      rxPrev_q <= rxPinIn;
  end

  // Mid-bit samples feeding the vote
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sampA_q <= 1'b1;
      sampB_q <= 1'b1;
    end
    else if (tick && tickCnt_q == SAMPLE_A)
      sampA_q <= rxPinIn;
    else if (tick && tickCnt_q == SAMPLE_B)
      sampB_q <= rxPinIn;
  end

  // Oversample phase counter restarts on the start edge
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      tickCnt_q <= 4'h0;
    else if (state_q == RX_IDLE)
      tickCnt_q <= 4'h0;
    else if (tick)
      tickCnt_q <= tickCnt_q + 4'h1;
  end

  // Character state machine; leaves the stop bit at its centre
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q  <= RX_IDLE;
      bitIdx_q <= 4'h0;
      shift_q  <= 9'h000;
    end
    else if (!rxRun)
      state_q <= RX_IDLE;
    else
    begin
      case (state_q)
        RX_IDLE:
        begin
          bitIdx_q <= 4'h0;
          if (rxPrev_q && !rxPinIn)
            state_q <= RX_START;
        end
        RX_START:
          if (evalTick)
            state_q <= vote ? RX_IDLE : RX_DATA;
        RX_DATA:
          if (evalTick)
          begin
            shift_q  <= {vote, shift_q[8:1]};
            bitIdx_q <= bitIdx_q + 4'h1;
            if (bitIdx_q == lastIdx)
              state_q <= RX_STOP;
          end
        RX_STOP:
          if (evalTick)
            state_q <= RX_IDLE;
        default:
          state_q <= RX_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Character delivery into the FIFO
  assign deliverEvt = rxRun && (state_q == RX_STOP) && evalTick;
  assign stopLow    = !vote;
  // Ninth bit passes raw; no parity is computed on it
  assign newEntry   = nineBit ? {stopLow, shift_q} : {stopLow, 1'b0, shift_q[8:1]};
  assign keepChar   = !addrFilter || shift_q[8];
  assign pushEvt    = deliverEvt && keepChar && (count_q != 2'd2);
  assign overrunSet = deliverEvt && keepChar && (count_q == 2'd2);
  assign headEntry  = (count_q != 2'd0) ? fifoMem_q[rdPtr_q] : 10'h000;

  // Storage; each entry keeps framing error and ninth bit with its data
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fifoMem_q[0] <= 10'h000;
      fifoMem_q[1] <= 10'h000;
    end
    else if (pushEvt)
      fifoMem_q[wrPtr_q] <= newEntry;
  end

  // Pointers and occupancy; a port disable resets both pointers and the count
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wrPtr_q <= 1'b0;
      rdPtr_q <= 1'b0;
      count_q <= 2'd0;
    end
    else if (!portEn)
    begin
      wrPtr_q <= 1'b0;
      rdPtr_q <= 1'b0;
      count_q <= 2'd0;
    end
    else
    begin
      if (pushEvt)
        wrPtr_q <= !wrPtr_q;
      if (popEvt)
        rdPtr_q <= !rdPtr_q;
      if (pushEvt && !popEvt)
        count_q <= count_q + 2'd1;
      else if (popEvt && !pushEvt)
        count_q <= count_q - 2'd1;
    end
  end

  // Last byte read out of the FIFO, returned by reads of an empty FIFO
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      lastData_q <= 8'h00;
    else if (popEvt)
      lastData_q <= headEntry[7:0];
  end

  // Overrun: set wins over a clear in the same cycle
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      overrun_q <= 1'b0;
    else if (overrunSet)
      overrun_q <= 1'b1;
    else if (!portEn || !rxCtl_q[RX_CONT])
      overrun_q <= 1'b0;
  end

  // ==========================================================================
  // Flags, interrupt and pin control; framing error never raises an interrupt
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rxReadyFlag <= 1'b0;
      rxIrq       <= 1'b0;
    end
    else
    begin
      rxReadyFlag <= portEn && rxCtl_q[RX_CONT] && (count_q != 2'd0);
      rxIrq       <= portEn && rxCtl_q[RX_CONT] && (count_q != 2'd0) &&
                     (irqCtl_q == 3'b111);
    end
  end

  // Pins: receive line stays released; transmit line driven idle-high only while the port is enabled
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rxPinOut        <= 1'b1;
      rxPinOe         <= 1'b0;
      txPinOut        <= 1'b1;
      txPinOe         <= 1'b0;
      txPathEnable    <= 1'b0;
      syncClockMaster <= 1'b0;
    end
    else
    begin
      rxPinOut        <= 1'b1;
      rxPinOe         <= 1'b0;
      txPinOut        <= 1'b1;
      txPinOe         <= portEn;
      txPathEnable    <= portEn && txCtl_q[TX_ENABLE] &&
                         !(syncMode && (rxCtl_q[RX_CONT] || rxCtl_q[RX_SINGLE]));
      syncClockMaster <= portEn && syncMode && txCtl_q[TX_CLKSRC];
    end
  end

  // ==========================================================================
  // Assertions
  a_ready_follows: assert property (@(posedge core_clk) disable iff (!rst_n)
    (portEn && rxCtl_q[RX_CONT] && count_q != 2'd0) |=> rxReadyFlag)
    else $error("ready flag missing with data in FIFO");

  a_irq_gated: assert property (@(posedge core_clk) disable iff (!rst_n)
    rxIrq |-> (rxReadyFlag && $past(irqCtl_q) == 3'b111))
    else $error("interrupt without all enables");

  a_framing_error_stored: assert property (@(posedge core_clk) disable iff (!rst_n)
    (pushEvt && count_q == 2'd0 && !popEvt && stopLow) |=> headEntry[9])
    else $error("framing error not shown for oldest character");

  a_pop_advances: assert property (@(posedge core_clk) disable iff (!rst_n)
    (popEvt && !pushEvt && portEn) |=> (count_q == $past(count_q) - 2'd1))
    else $error("data read did not advance FIFO");

  a_disable_flush: assert property (@(posedge core_clk) disable iff (!rst_n)
    !portEn |=> (count_q == 2'd0 && headEntry[9] == 1'b0))
    else $error("port disable left framing error");

  a_overrun_set: assert property (@(posedge core_clk) disable iff (!rst_n)
    (deliverEvt && keepChar && count_q == 2'd2) |=> (overrun_q && count_q == 2'd2))
    else $error("third character did not flag overrun");

  a_overrun_blocks: assert property (@(posedge core_clk) disable iff (!rst_n)
    overrun_q |-> (!pushEvt && state_q == RX_IDLE))
    else $error("character accepted during overrun");

  a_addr_filter: assert property (@(posedge core_clk) disable iff (!rst_n)
    (pushEvt && addrFilter) |=> fifoMem_q[$past(wrPtr_q)][8])
    else $error("address filter let a data character in");

  a_start_abort: assert property (@(posedge core_clk) disable iff (!rst_n)
    (rxRun && state_q == RX_START && evalTick && vote) |=> state_q == RX_IDLE)
    else $error("false start not abandoned");

  a_bus_answer: assert property (@(posedge core_clk) disable iff (!rst_n)
    ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one cycle");

endmodule

// ==== design/baud_tick.sv ====
// Baud timer producing the sixteen-times oversampling tick.
`timescale 1ns/100ps
module baud_tick #(
  parameter int DIV_W = 8,
  parameter int PRE_W = 2
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             clear,
  input  wire logic             lowSpeed,
  input  wire logic [DIV_W-1:0] divisor,
  output logic                  tick
);
  import async_rx_pkg::*;

  logic [DIV_W-1:0] cnt_q;
  logic [PRE_W-1:0] pre_q;
  logic             wrap;

  // ==========================================================================
  // Elaboration checks
  if (DIV_W < 1) $error("baud_tick: divisor width too small");
  if ((1 << PRE_W) != LOW_PRESCALE) $error("baud_tick: prescale width mismatch");

  // Period is n+1 clocks per tick, times four at low speed
  assign wrap = (cnt_q == divisor);
  assign tick = wrap && (!lowSpeed || (pre_q == {PRE_W{1'b1}}));

  // Divisor counter; clear restarts so a new rate takes effect at once
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_q <= '0;
    else if (clear || wrap)
      cnt_q <= '0;
    else
      cnt_q <= cnt_q + 1'b1;
  end

  // Low-speed prescaler
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      pre_q <= '0;
    else if (clear || !lowSpeed)
      pre_q <= '0;
    else if (wrap)
      pre_q <= pre_q + 1'b1;
  end

endmodule

// ==== dv/async_serial_receiver_ctl_tb.sv ====
// Self-checking bench for the asynchronous serial receiver.
`timescale 1ns/100ps
module async_serial_receiver_ctl_tb;
  import async_rx_pkg::*;
  // ==========================================================================
  // Signals
  logic              core_clk = 1'h0;
  logic              rst_n = 1'h0;
  logic [ADDR_W-1:0] avs_address = 5'h00;
  logic              avs_read = 1'h0;
  logic              avs_write = 1'h0;
  logic [DATA_W-1:0] avs_writedata = 32'h0;
  logic [3:0]        avs_byteenable = 4'hF;
  logic [DATA_W-1:0] avs_readdata;
  logic              avs_waitrequest;
  logic              rxLine;
  logic              rxPinOe;
  logic              txPinOe;
  logic              rxReadyFlag;
  logic              rxIrq;
  logic              syncClockMaster;
  logic              rxPinOut;
  logic              txPinOut;
  logic              txPathEnable;
  logic              sendReq = 1'h0;
  logic [8:0]        sendData = 9'h000;
  logic              sendNine = 1'h0;
  logic              badStop = 1'h0;
  logic [7:0]        bitClocks = 8'h10;
  logic              busy;
  int                mismatches = 0;
  int                samplesChecked = 0;

  // 100 MHz clock
  always #5 core_clk = ~core_clk;

  async_serial_receiver_ctl async_serial_receiver_ctl_i (
    .core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rxPinIn(rxLine),
    .rxPinOut(rxPinOut), .rxPinOe(rxPinOe), .txPinOut(txPinOut), .txPinOe(txPinOe),
    .rxReadyFlag(rxReadyFlag), .rxIrq(rxIrq), .txPathEnable(txPathEnable),
    .syncClockMaster(syncClockMaster));

  serial_tx_model serial_tx_model_i (
    .core_clk(core_clk), .sendReq(sendReq), .sendData(sendData), .sendNine(sendNine),
    .badStop(badStop), .bitClocks(bitClocks), .rxLine(rxLine), .busy(busy));

  // ==========================================================================
  // Verdict and comparisons
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", samplesChecked, mismatches);
    if (mismatches == 0 && samplesChecked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic checkReg(input string nm, input logic [31:0] e, input logic [31:0] g);
    samplesChecked++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic checkBit(input string nm, input logic e, input logic g);
    samplesChecked++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask

  // ==========================================================================
  // Bus and serial drivers; each held until the answering edge
  task automatic busXfer(input logic w, input logic [4:0] a, input logic [7:0] d,
                         output logic [31:0] q);
    int n;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= w;
    avs_read <= !w;
    for (n = 0; n < 50; n++)
    begin
      @(posedge core_clk);
      if (avs_waitrequest === 1'h0)
        break;
    end
    q = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
    // Extra edge keeps a request from being dropped and raised in one step
    @(posedge core_clk);
    if (n == 50)
    begin
      mismatches++;
      results();
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] q;
    busXfer(1'h1, a, d, q);
  endtask

  task automatic rdChk(input string nm, input logic [4:0] a, input logic [7:0] e);
    logic [31:0] q;
    busXfer(1'h0, a, 8'h00, q);
    checkReg(nm, {24'h0, e}, q);
  endtask

  task automatic sendChar(input logic [8:0] d, input logic nine, input logic bad);
    int n;
    sendData <= d;
    sendNine <= nine;
    badStop <= bad;
    sendReq <= 1'h1;
    @(posedge core_clk);
    sendReq <= 1'h0;
    @(posedge core_clk);
    for (n = 0; n < 1500 && busy !== 1'h0; n++)
      @(posedge core_clk);
    repeat (2) @(posedge core_clk);
    if (n == 1500)
    begin
      mismatches++;
      results();
    end
  endtask

  // ==========================================================================
  // Scenarios
  task automatic resetAndAccess();
    rdChk("txctl", OFS_TXCTL, TXCTL_RST);
    rdChk("rxctl", OFS_RXCTL, RXCTL_RST);
    rdChk("unmapped", 5'h18, 8'h00);
    wr(OFS_TXCTL, 8'hFF);
    rdChk("txctl", OFS_TXCTL, 8'hF7);
    avs_byteenable <= 4'h0;
    wr(OFS_BAUD, 8'h55);
    avs_byteenable <= 4'hF;
    rdChk("baud", OFS_BAUD, BAUD_RST);
  endtask

  task automatic basicReceive();
    wr(OFS_BAUD, 8'h00);
    wr(OFS_TXCTL, 8'h84);
    wr(OFS_RXCTL, 8'h90);
    sendChar(9'h0A5, 1'h0, 1'h0);
    checkBit("ready", 1'h1, rxReadyFlag);
    checkBit("irq", 1'h0, rxIrq);
    checkBit("clkmaster", 1'h0, syncClockMaster);
    checkBit("txoe", 1'h1, txPinOe);
    checkBit("rxoe", 1'h0, rxPinOe);
    rdChk("rxctl", OFS_RXCTL, 8'h90);
    rdChk("data", OFS_RXDATA, 8'hA5);
    @(posedge core_clk);
    checkBit("ready", 1'h0, rxReadyFlag);
  endtask

  task automatic framingAndOverrun();
    sendChar(9'h03C, 1'h0, 1'h1);
    sendChar(9'h0C3, 1'h0, 1'h0);
    rdChk("rxctl", OFS_RXCTL, 8'h94);
    rdChk("data", OFS_RXDATA, 8'h3C);
    rdChk("rxctl", OFS_RXCTL, 8'h90);
    rdChk("data", OFS_RXDATA, 8'hC3);
    rdChk("data", OFS_RXDATA, 8'hC3);
    rdChk("rxctl", OFS_RXCTL, 8'h90);
    sendChar(9'h011, 1'h0, 1'h0);
    sendChar(9'h022, 1'h0, 1'h0);
    sendChar(9'h033, 1'h0, 1'h0);
    rdChk("rxctl", OFS_RXCTL, 8'h92);
    rdChk("data", OFS_RXDATA, 8'h11);
    sendChar(9'h044, 1'h0, 1'h0);
    rdChk("data", OFS_RXDATA, 8'h22);
    @(posedge core_clk);
    checkBit("ready", 1'h0, rxReadyFlag);
    wr(OFS_RXCTL, 8'h80);
    rdChk("rxctl", OFS_RXCTL, 8'h80);
  endtask

  task automatic addressDetect();
    wr(OFS_RXCTL, 8'hD8);
    sendChar(9'h055, 1'h1, 1'h0);
    sendChar(9'h1AA, 1'h1, 1'h0);
    rdChk("rxctl", OFS_RXCTL, 8'hD9);
    rdChk("data", OFS_RXDATA, 8'hAA);
    wr(OFS_RXCTL, 8'hD0);
    sendChar(9'h055, 1'h1, 1'h0);
    rdChk("rxctl", OFS_RXCTL, 8'hD0);
    rdChk("data", OFS_RXDATA, 8'h55);
    wr(OFS_RXCTL, 8'h98);
    sendChar(9'h066, 1'h0, 1'h0);
    rdChk("data", OFS_RXDATA, 8'h66);
  endtask

  task automatic irqAndSlowBaud();
    wr(OFS_TXCTL, 8'h80);
    wr(OFS_BAUD, 8'h01);
    bitClocks <= 8'h80;
    wr(OFS_IRQCTL, 8'h07);
    sendChar(9'h05A, 1'h0, 1'h0);
    checkBit("irq", 1'h1, rxIrq);
    rdChk("irqflag", OFS_IRQFLG, 8'h01);
    wr(OFS_IRQCTL, 8'h03);
    @(posedge core_clk);
    checkBit("irq", 1'h0, rxIrq);
    checkBit("ready", 1'h1, rxReadyFlag);
    rdChk("data", OFS_RXDATA, 8'h5A);
  endtask

  task automatic portDisable();
    wr(OFS_TXCTL, 8'h84);
    wr(OFS_BAUD, 8'h00);
    bitClocks <= 8'h10;
    sendChar(9'h0E7, 1'h0, 1'h1);
    wr(OFS_RXCTL, 8'h88);
    rdChk("rxctl", OFS_RXCTL, 8'h8C);
    wr(OFS_RXCTL, 8'h08);
    rdChk("rxctl", OFS_RXCTL, 8'h08);
    @(posedge core_clk);
    checkBit("txoe", 1'h0, txPinOe);
  endtask

  // Short bits make the line high again at the start-bit centre: silent abort
  task automatic falseStartAndSync();
    wr(OFS_RXCTL, 8'h90);
    bitClocks <= 8'h04;
    sendChar(9'h0FE, 1'h0, 1'h0);
    bitClocks <= 8'h10;
    checkBit("ready", 1'h0, rxReadyFlag);
    rdChk("rxctl", OFS_RXCTL, 8'h90);
    // Synchronous master with single receive; it clears itself after one character
    wr(OFS_TXCTL, 8'hB0);
    wr(OFS_RXCTL, 8'hA0);
    @(posedge core_clk);
    checkBit("clkmaster", 1'h1, syncClockMaster);
    checkBit("txpath", 1'h0, txPathEnable);
    sendChar(9'h0B4, 1'h0, 1'h0);
    checkBit("txpath", 1'h1, txPathEnable);
    rdChk("rxctl", OFS_RXCTL, 8'h80);
    rdChk("data", OFS_RXDATA, 8'hB4);
    // Continuous set as well: single must survive the character
    wr(OFS_RXCTL, 8'hB0);
    sendChar(9'h04B, 1'h0, 1'h0);
    rdChk("rxctl", OFS_RXCTL, 8'hB0);
    rdChk("data", OFS_RXDATA, 8'h4B);
    checkBit("rxout", 1'h1, rxPinOut);
    checkBit("txout", 1'h1, txPinOut);
  endtask

  // ==========================================================================
  // Main sequence: reset held ten cycles, then every scenario in turn
  initial
  begin
    repeat (10) @(posedge core_clk);
    rst_n <= 1'h1;
    @(posedge core_clk);
    resetAndAccess();
    basicReceive();
    framingAndOverrun();
    addressDetect();
    irqAndSlowBaud();
    portDisable();
    falseStartAndSync();
    results();
  end
endmodule

// ==== dv/serial_tx_model.sv ====
// Behavioural remote transmitter driving the receive line of the block.
`timescale 1ns/100ps
module serial_tx_model (
  input  wire logic       core_clk,
  input  wire logic       sendReq,
  input  wire logic [8:0] sendData,
  input  wire logic       sendNine,
  input  wire logic       badStop,
  input  wire logic [7:0] bitClocks,
  output logic            rxLine,
  output logic            busy
);
  // ==========================================================================
  // Frame shifter
  logic [10:0] shift_q = 11'h7FF;
  logic [3:0]  bitsLeft_q = 4'h0;
  logic [7:0]  phase_q = 8'h00;

  initial
  begin
    rxLine = 1'h1;
    busy = 1'h0;
  end

  // Start low, data LSB first, stop level chosen by the bench; idle is high
  always @(posedge core_clk)
  begin
    if (!busy && sendReq)
    begin
      shift_q <= sendNine ? {~badStop, sendData, 1'h0}
                          : {1'h1, ~badStop, sendData[7:0], 1'h0};
      bitsLeft_q <= sendNine ? 4'hB : 4'hA;
      phase_q <= 8'h00;
      busy <= 1'h1;
      rxLine <= 1'h0;
    end
    else if (busy)
    begin
      // Whole bit times only, so the receiver's mid-bit vote sees a flat level
      if (phase_q == bitClocks - 8'h01)
      begin
        phase_q <= 8'h00;
        bitsLeft_q <= bitsLeft_q - 4'h1;
        rxLine <= (bitsLeft_q == 4'h1) ? 1'h1 : shift_q[1];
        shift_q <= {1'h1, shift_q[10:1]};
        busy <= (bitsLeft_q != 4'h1);
      end
      else
        phase_q <= phase_q + 8'h01;
    end
  end
endmodule
